//--- sar_pkg.sv
// shared constants for the serial converter read-out link
package sar_pkg;

  // system clock and link timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int ACQUIRE_NS     = 350;
  localparam int ACQUIRE_CYC    = (ACQUIRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_NS       = 50;
  localparam int QUIET_CYC      = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC  = 4;

  // frame layout
  localparam int LEAD_ZEROS     = 3;
  localparam int DATA_BITS      = 8;
  localparam int TRAIL_ZEROS    = 4;
  localparam int WORD_W         = 1 + LEAD_ZEROS + DATA_BITS + TRAIL_ZEROS;
  localparam int CNT_W          = 5;

  // edge counts that steer the sequence
  localparam logic [CNT_W-1:0] FRAME_FALLS = 5'h10;
  localparam logic [CNT_W-1:0] TRACK_RISE  = 5'h0D;
  localparam logic [CNT_W-1:0] SHDN_FROM   = 5'h02;
  localparam logic [CNT_W-1:0] NORMAL_FROM = 5'h0A;

  // converter end sequence states
  typedef enum logic [0:0] {
    SAR_DEV_IDLE = 1'b0,
    SAR_DEV_CONV = 1'b1
  } sar_dev_state_e;

  // host end sequence states
  typedef enum logic [1:0] {
    SAR_HOST_IDLE  = 2'b00,
    SAR_HOST_SETUP = 2'b01,
    SAR_HOST_RUN   = 2'b10,
    SAR_HOST_GAP   = 2'b11
  } sar_host_state_e;

endpackage

//--- sar_link_if.sv
// three-wire link (select, clock, data) between the converter end and the host end
`timescale 1ns/10ps
`default_nettype none
interface sar_link_if;
  logic cs_n;
  logic sclk;
  logic serial_out;
  logic serial_out_oe;
  logic serial_out_line;

  // floating data line resolves low, like a weak pull-down
  assign serial_out_line = serial_out_oe ? serial_out : 1'b0;

  modport dev (
    input  cs_n,
    input  sclk,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output cs_n,
    output sclk,
    input  serial_out_line
  );
endinterface
`default_nettype wire

//--- sar_dev.sv
// converter end: frames, sequencing and serial output of the 8-bit converter
`timescale 1ns/10ps
`default_nettype none
module sar_dev (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  sar_link_if.dev                        link,
  input  wire logic [sar_pkg::DATA_BITS-1:0] code_in,
  output logic                           tracking_out,
  output logic                           shutdown_out,
  output logic                           frame_done_out,
  output logic                           aborted_out
);

  // synchronisers for the two link inputs, plus one stage for edges
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;

  // sequence state
  sar_pkg::sar_dev_state_e    st_r;
  sar_pkg::sar_dev_state_e    st_nxt;
  logic [sar_pkg::CNT_W-1:0]  fall_cnt_r;
  logic [sar_pkg::CNT_W-1:0]  fall_cnt_nxt;
  logic [sar_pkg::CNT_W-1:0]  rise_cnt_r;
  logic [sar_pkg::CNT_W-1:0]  rise_cnt_nxt;
  logic [sar_pkg::WORD_W-1:0] word_r;
  logic [sar_pkg::WORD_W-1:0] word_nxt;
  logic                       dout_r;
  logic                       dout_nxt;
  logic                       oe_r;
  logic                       oe_nxt;
  logic                       track_r;
  logic                       track_nxt;
  logic                       shut_r;
  logic                       shut_nxt;
  logic                       done_r;
  logic                       done_nxt;
  logic                       abort_r;
  logic                       abort_nxt;

  // edge strobes, all taken from the second and third stages only
  // a select fall and a clock edge in one cycle: the select fall wins
  logic                       cs_fall;
  logic                       cs_rise;
  logic                       sclk_fall;
  logic                       sclk_rise;
  logic [sar_pkg::CNT_W-1:0]  fall_inc;
  logic [sar_pkg::CNT_W-1:0]  rise_inc;

  assign cs_fall   = cs_s3_r & ~cs_s2_r;
  assign cs_rise   = ~cs_s3_r & cs_s2_r;
  assign sclk_fall = sclk_s3_r & ~sclk_s2_r;
  assign sclk_rise = ~sclk_s3_r & sclk_s2_r;
  assign fall_inc  = fall_cnt_r + 5'h01;
  assign rise_inc  = rise_cnt_r + 5'h01;

  // pins come from the host's domain, so two flops before any use
  // the host must hold each clock level three reference cycles, or a bit
  // driven three cycles after a fall is not settled at the next fall
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
    end else begin
      cs_s1_r   <= link.cs_n;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
    end
  end

  // next-state logic; a select fall outranks any clock edge in the same cycle
  always_comb begin
    st_nxt       = st_r;
    fall_cnt_nxt = fall_cnt_r;
    rise_cnt_nxt = rise_cnt_r;
    word_nxt     = word_r;
    dout_nxt     = dout_r;
    oe_nxt       = oe_r;
    track_nxt    = track_r;
    shut_nxt     = shut_r;
    done_nxt     = 1'b0;
    abort_nxt    = 1'b0;
    if (cs_fall) begin
      // sample the code, enter hold and drive the first zero
      st_nxt       = sar_pkg::SAR_DEV_CONV;
      fall_cnt_nxt = '0;
      rise_cnt_nxt = '0;
      word_nxt     = {{(sar_pkg::LEAD_ZEROS + 1){1'b0}},
                      code_in,
                      {(sar_pkg::TRAIL_ZEROS){1'b0}}};
      dout_nxt     = 1'b0;
      oe_nxt       = 1'b1;
      track_nxt    = 1'b0;
      // mode is left alone here: a select pulse too short to reach the
      // second fall must not wake a converter that was shut down
    end else if (st_r == sar_pkg::SAR_DEV_CONV) begin
      if (cs_rise) begin
        // early release truncates the word; mode depends on falls so far
        st_nxt    = sar_pkg::SAR_DEV_IDLE;
        oe_nxt    = 1'b0;
        track_nxt = 1'b1;
        abort_nxt = 1'b1;
        if (fall_cnt_r >= sar_pkg::NORMAL_FROM) begin
          shut_nxt = 1'b0;
        end else if (fall_cnt_r >= sar_pkg::SHDN_FROM) begin
          shut_nxt = 1'b1;
        end else begin
          shut_nxt = shut_r;
        end
      end else begin
        if (sclk_rise) begin
          rise_cnt_nxt = rise_inc;
          if (rise_inc == sar_pkg::TRACK_RISE) begin
            track_nxt = 1'b1;
          end
        end
        if (sclk_fall) begin
          fall_cnt_nxt = fall_inc;
          // the tenth fall commits the converter to normal mode
          if (fall_inc == sar_pkg::NORMAL_FROM) begin
            shut_nxt = 1'b0;
          end
          if (fall_inc == sar_pkg::FRAME_FALLS) begin
            // whole word out: release the line and wait for the next select
            st_nxt   = sar_pkg::SAR_DEV_IDLE;
            oe_nxt   = 1'b0;
            dout_nxt = 1'b0;
            done_nxt = 1'b1;
          end else begin
            // next bit goes out on this fall, host takes it on the next one
            dout_nxt = word_r[sar_pkg::WORD_W-2];
            word_nxt = {word_r[sar_pkg::WORD_W-2:0], 1'b0};
          end
        end
      end
    end
  end

  // registers only; power-up mode is taken as normal and tracking
  // a shutdown set by an early release lasts until a frame reaches ten falls
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r       <= sar_pkg::SAR_DEV_IDLE;
      fall_cnt_r <= '0;
      rise_cnt_r <= '0;
      word_r     <= '0;
      dout_r     <= 1'b0;
      oe_r       <= 1'b0;
      track_r    <= 1'b1;
      shut_r     <= 1'b0;
      done_r     <= 1'b0;
      abort_r    <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      fall_cnt_r <= fall_cnt_nxt;
      rise_cnt_r <= rise_cnt_nxt;
      word_r     <= word_nxt;
      dout_r     <= dout_nxt;
      oe_r       <= oe_nxt;
      track_r    <= track_nxt;
      shut_r     <= shut_nxt;
      done_r     <= done_nxt;
      abort_r    <= abort_nxt;
    end
  end

  // link and status outputs all come straight from flops
  assign link.serial_out    = dout_r;
  assign link.serial_out_oe = oe_r;
  assign tracking_out       = track_r;
  assign shutdown_out       = shut_r;
  assign frame_done_out     = done_r;
  assign aborted_out        = abort_r;

endmodule
`default_nettype wire

//--- sar_host.sv
// host end: drives select and serial clock, collects the 8-bit result
`timescale 1ns/10ps
`default_nettype none
module sar_host #(
  parameter int SCLK_HALF = sar_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC   = sar_pkg::ACQUIRE_CYC + sar_pkg::QUIET_CYC
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  sar_link_if.host                       link,
  input  wire logic                      start_in,
  input  wire logic [sar_pkg::CNT_W-1:0] falls_in,
  output logic                           ready_out,
  output logic [sar_pkg::DATA_BITS-1:0]  result_out,
  output logic                           result_valid_out,
  output logic                           result_usable_out
);

  localparam int TW = 8;

  sar_pkg::sar_host_state_e   st_r;
  sar_pkg::sar_host_state_e   st_nxt;
  logic [TW-1:0]              tmr_r;
  logic [TW-1:0]              tmr_nxt;
  logic [sar_pkg::CNT_W-1:0]  target_r;
  logic [sar_pkg::CNT_W-1:0]  target_nxt;
  logic [sar_pkg::CNT_W-1:0]  falls_r;
  logic [sar_pkg::CNT_W-1:0]  falls_nxt;
  logic [sar_pkg::WORD_W-1:0] shift_r;
  logic [sar_pkg::WORD_W-1:0] shift_nxt;
  logic                       cs_n_r;
  logic                       cs_n_nxt;
  logic                       sclk_r;
  logic                       sclk_nxt;
  logic                       dummy_r;
  logic                       dummy_nxt;
  logic [sar_pkg::DATA_BITS-1:0] res_r;
  logic [sar_pkg::DATA_BITS-1:0] res_nxt;
  logic                       vld_r;
  logic                       vld_nxt;
  logic                       use_r;
  logic                       use_nxt;
  logic                       din_s1_r;
  logic                       din_s2_r;

  // data pin comes from the converter's side, two flops before use
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end else begin
      din_s1_r <= link.serial_out_line;
      din_s2_r <= din_s1_r;
    end
  end

  // sequence; the clock idles high so the first edge after select is a fall
  always_comb begin
    st_nxt     = st_r;
    tmr_nxt    = tmr_r;
    target_nxt = target_r;
    falls_nxt  = falls_r;
    shift_nxt  = shift_r;
    cs_n_nxt   = cs_n_r;
    sclk_nxt   = sclk_r;
    dummy_nxt  = dummy_r;
    res_nxt    = res_r;
    vld_nxt    = 1'b0;
    use_nxt    = use_r;
    unique case (st_r)
      sar_pkg::SAR_HOST_IDLE: begin
        if (start_in) begin
          // zero or too many falls means a full read
          if (falls_in == '0 || falls_in > sar_pkg::FRAME_FALLS) begin
            target_nxt = sar_pkg::FRAME_FALLS;
          end else begin
            target_nxt = falls_in;
          end
          falls_nxt = '0;
          cs_n_nxt  = 1'b0;
          tmr_nxt   = TW'(SCLK_HALF - 1);
          st_nxt    = sar_pkg::SAR_HOST_SETUP;
        end
      end
      sar_pkg::SAR_HOST_SETUP,
      sar_pkg::SAR_HOST_RUN: begin
        if (tmr_r != '0) begin
          tmr_nxt = tmr_r - 8'h01;
        end else if (sclk_r && falls_r != target_r) begin
          // fall: take the bit shifted on the previous fall
          sclk_nxt  = 1'b0;
          falls_nxt = falls_r + 5'h01;
          shift_nxt = {shift_r[sar_pkg::WORD_W-2:0], din_s2_r};
          tmr_nxt   = TW'(SCLK_HALF - 1);
          st_nxt    = sar_pkg::SAR_HOST_RUN;
        end else if (!sclk_r && falls_r != target_r) begin
          sclk_nxt = 1'b1;
          tmr_nxt  = TW'(SCLK_HALF - 1);
        end else begin
          // end of frame: release select, then leave acquire and quiet time
          sclk_nxt = 1'b1;
          cs_n_nxt = 1'b1;
          tmr_nxt  = TW'(GAP_CYC);
          st_nxt   = sar_pkg::SAR_HOST_GAP;
          if (target_r == sar_pkg::FRAME_FALLS) begin
            res_nxt = shift_r[sar_pkg::TRAIL_ZEROS +: sar_pkg::DATA_BITS];
            vld_nxt = 1'b1;
            use_nxt = ~dummy_r;
          end
          if (target_r >= sar_pkg::NORMAL_FROM) begin
            dummy_nxt = 1'b0;
          end else if (target_r >= sar_pkg::SHDN_FROM) begin
            dummy_nxt = 1'b1;
          end
        end
      end
      sar_pkg::SAR_HOST_GAP: begin
        if (tmr_r != '0) begin
          tmr_nxt = tmr_r - 8'h01;
        end else begin
          st_nxt = sar_pkg::SAR_HOST_IDLE;
        end
      end
    endcase
  end

  // registers only; mode of the converter is unknown after reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r     <= sar_pkg::SAR_HOST_IDLE;
      tmr_r    <= '0;
      target_r <= sar_pkg::FRAME_FALLS;
      falls_r  <= '0;
      shift_r  <= '0;
      cs_n_r   <= 1'b1;
      sclk_r   <= 1'b1;
      dummy_r  <= 1'b1;
      res_r    <= '0;
      vld_r    <= 1'b0;
      use_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      target_r <= target_nxt;
      falls_r  <= falls_nxt;
      shift_r  <= shift_nxt;
      cs_n_r   <= cs_n_nxt;
      sclk_r   <= sclk_nxt;
      dummy_r  <= dummy_nxt;
      res_r    <= res_nxt;
      vld_r    <= vld_nxt;
      use_r    <= use_nxt;
    end
  end

  assign link.cs_n         = cs_n_r;
  assign link.sclk         = sclk_r;
  assign ready_out         = (st_r == sar_pkg::SAR_HOST_IDLE);
  assign result_out        = res_r;
  assign result_valid_out  = vld_r;
  assign result_usable_out = use_r;

endmodule
`default_nettype wire

//--- sar_link_properties.sv
// wire checks on the select, clock and data lines of the read-out link
`timescale 1ns/10ps
`default_nettype none
module sar_link_properties (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic serial_out_line
);
  logic       sclk_q_r;
  logic       cs_q_r;
  logic       sclk_fall;
  logic [4:0] falls_r;
  logic [4:0] falls_nxt;

  // clock falls in this frame; saturates so stray edges never wrap it
  always_comb begin
    sclk_fall = sclk_q_r && !sclk;
    falls_nxt = falls_r;
    if (cs_q_r && !cs_n) begin
      falls_nxt = 5'h00;
    end else if (!cs_n && sclk_fall && falls_r != 5'h1F) begin
      falls_nxt = falls_r + 5'h01;
    end
  end

  // idle-high reset values, so no false edge is seen after reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sclk_q_r <= 1'b1;
      cs_q_r   <= 1'b1;
      falls_r  <= 5'h00;
    end else begin
      sclk_q_r <= sclk;
      cs_q_r   <= cs_n;
      falls_r  <= falls_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // synchroniser delay allows two to four cycles between pin and output
  chk_oe_on_select: assert property (
    $fell(cs_n) |-> !serial_out_oe ##[2:4] (serial_out_oe && !serial_out))
    else $error("select fall did not enable the output");
  chk_oe_holds_frame: assert property (
    (!cs_n && serial_out_oe && falls_r < 5'h10) |=> serial_out_oe)
    else $error("output dropped inside the frame");
  chk_float_on_rise: assert property (
    $rose(cs_n) |-> ##[1:4] !serial_out_oe)
    else $error("output still driven after select rise");
  chk_float_after_last: assert property (
    (sclk_fall && !cs_n && falls_r == 5'h0F) |-> ##[2:4] !serial_out_oe)
    else $error("output still driven after last fall");
  chk_float_idle: assert property (
    cs_n [*5] |-> !serial_out_oe)
    else $error("output driven while deselected");
  chk_zero_bits: assert property (
    (sclk_fall && !cs_n && (falls_r < 5'h04 || (falls_r > 5'h0B && falls_r < 5'h10)))
      |-> (serial_out_oe && !serial_out_line))
    else $error("padding bit not zero");
  chk_bit_stable: assert property (
    (sclk_fall && !cs_n) |-> $stable(serial_out) ##1 $stable(serial_out))
    else $error("data bit moved at the capture fall");
  chk_sclk_idle_high: assert property (
    cs_n [*2] |-> sclk)
    else $error("serial clock low outside a frame");
endmodule
`default_nettype wire

//--- tb_serial_adc_readout_frame.sv
// self-checking bench: host end and converter end joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb_serial_adc_readout_frame;
  logic        ref_clk_in;
  logic        rst_in;
  logic        start_in;
  logic [4:0]  falls_in;
  logic [7:0]  code_in;
  logic        ready_out;
  logic [7:0]  result_out;
  logic        result_valid_out;
  logic        result_usable_out;
  logic        tracking_out;
  logic        shutdown_out;
  logic        frame_done_out;
  logic        aborted_out;
  logic [15:0] cap;
  logic [7:0]  exp_res;
  logic        sclk_q;
  logic        cs_q;
  int          fails;
  int          total_checks;
  int          cycles;
  int          n_fall;
  int          n_rise;
  int          since_track;
  int          n_done;
  int          n_abort;
  int          n_valid;
  // frame plan: falls, mode after, usable flag, four boundary codes
  logic [4:0]  f_tab [11] = '{5'h00, 5'h10, 5'h01, 5'h02, 5'h01, 5'h10, 5'h10, 5'h09,
                               5'h0A, 5'h0F, 5'h10};
  logic        sd_tab [11] = '{0, 0, 0, 1, 1, 0, 0, 1, 0, 0, 0};
  logic        use_tab [11] = '{0, 1, 0, 0, 0, 0, 1, 0, 0, 0, 1};
  logic [7:0]  code_tab [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};

  sar_link_if i_sar_link_if ();
  sar_dev i_sar_dev (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(i_sar_link_if),
    .code_in(code_in), .tracking_out(tracking_out), .shutdown_out(shutdown_out),
    .frame_done_out(frame_done_out), .aborted_out(aborted_out));
  sar_host i_sar_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(i_sar_link_if),
    .start_in(start_in), .falls_in(falls_in), .ready_out(ready_out),
    .result_out(result_out), .result_valid_out(result_valid_out),
    .result_usable_out(result_usable_out));
  sar_link_properties i_sar_link_properties (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cs_n(i_sar_link_if.cs_n), .sclk(i_sar_link_if.sclk),
    .serial_out(i_sar_link_if.serial_out), .serial_out_oe(i_sar_link_if.serial_out_oe),
    .serial_out_line(i_sar_link_if.serial_out_line));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // hang guard: eleven frames need under two thousand cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      conclude();
    end
  end

  // watch the wire at the falling edge, when every flop has settled
  always @(negedge ref_clk_in) begin
    if (!rst_in) begin
      since_track++;
      if (cs_q && !i_sar_link_if.cs_n) begin
        check(16'(since_track >= sar_pkg::ACQUIRE_CYC), 16'h0001, "acquire gap");
        n_fall = 0;
        n_rise = 0;
        cap = 16'h0000;
      end
      if (!i_sar_link_if.cs_n && sclk_q && !i_sar_link_if.sclk) begin
        n_fall++;
        cap = {cap[14:0], i_sar_link_if.serial_out_line};
        if (n_fall > 1) check(16'(tracking_out), 16'(n_fall > 13), "track");
      end
      if (!i_sar_link_if.cs_n && !sclk_q && i_sar_link_if.sclk) begin
        n_rise++;
        if (n_rise == 13) since_track = 0;
      end
      n_done += int'(frame_done_out === 1'b1);
      n_abort += int'(aborted_out === 1'b1);
      n_valid += int'(result_valid_out === 1'b1);
    end
    cs_q = i_sar_link_if.cs_n;
    sclk_q = i_sar_link_if.sclk;
  end

  // one frame from start to ready, then wire content, result and mode
  task automatic run_frame(input logic [4:0] f, input logic [7:0] code, input logic sd,
                           input logic use_exp);
    int          k;
    int          nf;
    int          v0;
    int          d0;
    int          a0;
    logic [15:0] w;
    v0 = n_valid;
    d0 = n_done;
    a0 = n_abort;
    w = {4'h0, code, 4'h0};
    nf = (f == 5'h00 || f > 5'h10) ? 16 : int'(f);
    @(posedge ref_clk_in);
    #1;
    start_in = 1'b1;
    falls_in = f;
    code_in = code;
    @(posedge ref_clk_in);
    #1;
    start_in = 1'b0;
    k = 0;
    while (ready_out !== 1'b1 && k < 400) begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end
    check(16'(k < 400), 16'h0001, "ready return");
    check(16'(n_fall), 16'(nf), "falls per frame");
    check(cap, w >> (16 - nf), "wire bits");
    if (nf == 16) begin
      exp_res = code;
      check(16'(n_valid - v0), 16'h0001, "valid");
      check(16'(n_done - d0), 16'h0001, "done");
      check(16'(n_abort - a0), 16'h0000, "no abort");
      check({15'h0000, result_usable_out}, {15'h0000, use_exp}, "usable");
    end else begin
      check(16'(n_abort - a0), 16'h0001, "abort");
      check(16'(n_valid - v0), 16'h0000, "no valid");
      check(16'(n_done - d0), 16'h0000, "no done");
    end
    check({8'h00, result_out}, {8'h00, exp_res}, "result");
    check({15'h0000, shutdown_out}, {15'h0000, sd}, "mode");
  endtask

  // reset, idle values, then the frame plan
  initial begin
    rst_in = 1'b1;
    start_in = 1'b0;
    falls_in = 5'h00;
    code_in = 8'h00;
    exp_res = 8'h00;
    cap = 16'h0000;
    cs_q = 1'b1;
    sclk_q = 1'b1;
    since_track = 1000;
    repeat (3) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    check({12'h000, i_sar_link_if.cs_n, i_sar_link_if.sclk, i_sar_link_if.serial_out_oe,
           tracking_out}, 16'h000D, "idle link");
    check({6'h00, shutdown_out, ready_out, result_out}, 16'h0100, "idle host");
    repeat (3) @(posedge ref_clk_in);
    for (int i = 0; i < 11; i++) begin
      run_frame(f_tab[i], code_tab[(i / 2) % 4], sd_tab[i], use_tab[i]);
    end
    conclude();
  end
endmodule
`default_nettype wire
